// >>> core/virs_params.svh
`ifndef VIRS_PARAMS_SVH
`define VIRS_PARAMS_SVH

// register offsets
`define VIRS_ADDR_SEL        8'h00
`define VIRS_ADDR_OUTCTL     8'h03
`define VIRS_ADDR_PWR        8'h0F
`define VIRS_ADDR_ROUTE01    8'hC3
`define VIRS_ADDR_ROUTE2     8'hC4

// field positions
`define VIRS_SEL_LSB         0
`define VIRS_SEL_MSB         3
`define VIRS_TRISTATE_BIT    6
`define VIRS_PD_PRIO_BIT     2
`define VIRS_PD_BIT          5
`define VIRS_MAN_EN_BIT      7
`define VIRS_R0_LSB          0
`define VIRS_R1_LSB          4
`define VIRS_R2_LSB          0

// reset values
`define VIRS_SEL_RST         4'h0
`define VIRS_REG_RST         8'h00

// selection code boundaries
`define VIRS_SEL_CVBS_LAST   4'h5
`define VIRS_SEL_YC1         4'h6
`define VIRS_SEL_YC2         4'h7
`define VIRS_SEL_YC3         4'h8
`define VIRS_SEL_COMP1       4'h9
`define VIRS_SEL_COMP2       4'hA
`define VIRS_SEL_CVBS7       4'hB
`define VIRS_SEL_HI_OFFSET   4'h4

// manual route code windows
`define VIRS_MAN_LO_FIRST    4'h1
`define VIRS_MAN_LO_LAST     4'h6
`define VIRS_MAN_HI_FIRST    4'h9
`define VIRS_MAN_HI_LAST     4'hE
`define VIRS_MAN_HI_OFFSET   4'h2

// per-converter masks of usable manual codes (bit n = code n)
`define VIRS_MASK_CONV0      16'h7E7E
`define VIRS_MASK_CONV1      16'h7878
`define VIRS_MASK_CONV2      16'h6464

// analog input numbers (0 = no connection)
`define VIRS_IN_NONE         4'h0
`define VIRS_IN1             4'h1
`define VIRS_IN2             4'h2
`define VIRS_IN3             4'h3
`define VIRS_IN4             4'h4
`define VIRS_IN5             4'h5
`define VIRS_IN6             4'h6

`endif

// >>> core/virs_pkg.sv
package virs_pkg;

   typedef enum logic [1:0] {
      VIRS_FMT_COMPOSITE,
      VIRS_FMT_YC,
      VIRS_FMT_COMPONENT
   } virs_fmt_t;

   typedef logic [3:0] virs_input_t;

endpackage : virs_pkg

// >>> core/virs_route_select.sv
`include "virs_params.svh"

// What this block does
// R01: a 4-bit selection field picks the analog inputs and decoded video format
// R02: the selection code also sets the core to composite, Y/C or component
// R03: after reset the selection field is 0000, composite from input 1
// R04: codes 0000-0101 composite inputs 1-6; 1011-1111 composite inputs 7-11
// R05: 0110/0111/1000 Y/C pairs 1-4,2-5,3-6; 1001 component 1/4/5, 1010 2/3/6
// R06: input 12 is reachable only through manual route codes
// R07: manual path with enable bit and three per-converter route fields
// R08: controller drives power-down pin low to power down, high to run
// R09: output-enable pin low with tristate bit 6 of 03 clear drives pixel bus; high floats pixels, syncs, lock stream
// R10: manual routes win for the switches; selection code still sets the format
// R11: manual override acts only while enable bit 7 of C4 is set; 4-bit fields
// R12: with priority bit 0 the pin controls core power-down, register bit ignored
module virs_route_select #(
   parameter int PIX_W = 20
) (
   input  wire logic                mclk_i,                   // 125 MHz clock
   input  wire logic                rst_b_i,                  // sync reset, active low
   input  wire logic                reg_wr_i,                 // register write strobe
   input  wire logic                reg_rd_i,                 // register read strobe
   input  wire logic [7:0]          reg_addr_i,               // register address
   input  wire logic [7:0]          reg_wdata_i,              // write data
   output logic      [7:0]          reg_rdata_o,              // read data
   input  wire logic                power_down_n_pin_i,       // power-down pin, active low
   input  wire logic                output_enable_n_i,        // output-enable pin, active low
   input  wire logic [PIX_W-1:0]    pixel_i,                  // pixel data from core
   input  wire logic                horiz_sync_i,             // hsync from core
   input  wire logic                vert_sync_i,              // vsync from core
   input  wire logic                subcarrier_lock_i,        // lock stream from core
   output logic      [PIX_W-1:0]    pixel_o,                  // pixel bus out
   output logic      [PIX_W-1:0]    pixel_oe_o,               // pixel bus enables
   output logic                     horiz_sync_out_o,         // hsync pin out
   output logic                     horiz_sync_oe_o,          // hsync enable
   output logic                     vert_sync_out_o,          // vsync pin out
   output logic                     vert_sync_oe_o,           // vsync enable
   output logic                     subcarrier_lock_stream_o, // lock stream pin out
   output logic                     subcarrier_lock_oe_o,     // lock stream enable
   output virs_pkg::virs_input_t    conv0_input_o,            // input at converter 0
   output virs_pkg::virs_input_t    conv1_input_o,            // input at converter 1
   output virs_pkg::virs_input_t    conv2_input_o,            // input at converter 2
   output virs_pkg::virs_fmt_t      core_format_o,            // decode format for core
   output logic                     core_power_down_o         // core power-down, active high
);
   import virs_pkg::*;

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   logic [3:0] input_format_select_ff;
   logic       tristate_ff;
   logic       power_down_priority_ff;
   logic       power_down_bit_ff;
   logic       manual_route_enable_ff;
   logic [3:0] conv0_route_code_ff;
   logic [3:0] conv1_route_code_ff;
   logic [3:0] conv2_route_code_ff;
   logic [7:0] reg_rdata_ff;
   logic [7:0] nxt_rdata;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         input_format_select_ff <= `VIRS_SEL_RST;                                  // R03
      end else if (reg_wr_i && reg_addr_i == `VIRS_ADDR_SEL) begin
         input_format_select_ff <= reg_wdata_i[`VIRS_SEL_MSB:`VIRS_SEL_LSB];       // R01
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         tristate_ff            <= 1'b0;
         power_down_priority_ff <= 1'b0;
         power_down_bit_ff      <= 1'b0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `VIRS_ADDR_OUTCTL) begin
            tristate_ff <= reg_wdata_i[`VIRS_TRISTATE_BIT];
         end
         if (reg_addr_i == `VIRS_ADDR_PWR) begin
            power_down_priority_ff <= reg_wdata_i[`VIRS_PD_PRIO_BIT];
            power_down_bit_ff      <= reg_wdata_i[`VIRS_PD_BIT];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         manual_route_enable_ff <= 1'b0;
         conv0_route_code_ff    <= 4'h0;
         conv1_route_code_ff    <= 4'h0;
         conv2_route_code_ff    <= 4'h0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `VIRS_ADDR_ROUTE01) begin
            conv0_route_code_ff <= reg_wdata_i[`VIRS_R0_LSB +: 4];                 // R11
            conv1_route_code_ff <= reg_wdata_i[`VIRS_R1_LSB +: 4];                 // R11
         end
         if (reg_addr_i == `VIRS_ADDR_ROUTE2) begin
            manual_route_enable_ff <= reg_wdata_i[`VIRS_MAN_EN_BIT];               // R07
            conv2_route_code_ff    <= reg_wdata_i[`VIRS_R2_LSB +: 4];              // R11
         end
      end
   end

   always_comb begin
      nxt_rdata = 8'h00;
      case (reg_addr_i)
         `VIRS_ADDR_SEL:     nxt_rdata[`VIRS_SEL_MSB:`VIRS_SEL_LSB] = input_format_select_ff;
         `VIRS_ADDR_OUTCTL:  nxt_rdata[`VIRS_TRISTATE_BIT] = tristate_ff;
         `VIRS_ADDR_PWR: begin
            nxt_rdata[`VIRS_PD_PRIO_BIT] = power_down_priority_ff;
            nxt_rdata[`VIRS_PD_BIT]      = power_down_bit_ff;
         end
         `VIRS_ADDR_ROUTE01: nxt_rdata = {conv1_route_code_ff, conv0_route_code_ff};
         `VIRS_ADDR_ROUTE2:  nxt_rdata = {manual_route_enable_ff, 3'h0, conv2_route_code_ff};
         default:            nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = reg_rdata_ff;

   // ----------------------------------------------------------------------
   // pre-assigned routing and format from the selection code
   // ----------------------------------------------------------------------
   virs_input_t sel_route [3];
   virs_fmt_t   sel_fmt;

   always_comb begin
      sel_route[0] = `VIRS_IN_NONE;
      sel_route[1] = `VIRS_IN_NONE;
      sel_route[2] = `VIRS_IN_NONE;
      sel_fmt      = VIRS_FMT_COMPOSITE;
      case (input_format_select_ff)                                                // R01 R02
         `VIRS_SEL_YC1: begin                                                      // R05
            sel_route[0] = `VIRS_IN1;
            sel_route[1] = `VIRS_IN4;
            sel_fmt      = VIRS_FMT_YC;
         end
         `VIRS_SEL_YC2: begin                                                      // R05
            sel_route[0] = `VIRS_IN2;
            sel_route[1] = `VIRS_IN5;
            sel_fmt      = VIRS_FMT_YC;
         end
         `VIRS_SEL_YC3: begin                                                      // R05
            sel_route[0] = `VIRS_IN3;
            sel_route[1] = `VIRS_IN6;
            sel_fmt      = VIRS_FMT_YC;
         end
         `VIRS_SEL_COMP1: begin                                                    // R05
            sel_route[0] = `VIRS_IN1;
            sel_route[1] = `VIRS_IN4;
            sel_route[2] = `VIRS_IN5;
            sel_fmt      = VIRS_FMT_COMPONENT;
         end
         `VIRS_SEL_COMP2: begin                                                    // R05
            sel_route[0] = `VIRS_IN2;
            sel_route[1] = `VIRS_IN3;
            sel_route[2] = `VIRS_IN6;
            sel_fmt      = VIRS_FMT_COMPONENT;
         end
         default: begin
            // composite: inputs 1-6 and 7-11; input 12 never reached here
            if (input_format_select_ff <= `VIRS_SEL_CVBS_LAST) begin              // R04
               sel_route[0] = input_format_select_ff + 4'h1;
            end else begin
               sel_route[0] = input_format_select_ff - `VIRS_SEL_HI_OFFSET;       // R04 R06
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // manual routing, one decoder per converter
   // ----------------------------------------------------------------------
   localparam logic [15:0] MAN_MASK [3] = '{`VIRS_MASK_CONV0, `VIRS_MASK_CONV1, `VIRS_MASK_CONV2};
   logic [3:0] man_code [3];
   virs_input_t conv_ff [3];

   assign man_code[0] = conv0_route_code_ff;
   assign man_code[1] = conv1_route_code_ff;
   assign man_code[2] = conv2_route_code_ff;

   for (genvar g = 0; g < 3; g++) begin : g_conv
      virs_input_t man_route;
      always_comb begin
         man_route = `VIRS_IN_NONE;
         if (MAN_MASK[g][man_code[g]]) begin
            if (man_code[g] >= `VIRS_MAN_HI_FIRST && man_code[g] <= `VIRS_MAN_HI_LAST) begin
               man_route = man_code[g] - `VIRS_MAN_HI_OFFSET;                      // R06
            end else if (man_code[g] >= `VIRS_MAN_LO_FIRST && man_code[g] <= `VIRS_MAN_LO_LAST) begin
               man_route = man_code[g];
            end
         end
      end
      always_ff @(posedge mclk_i) begin
         if (!rst_b_i) begin
            conv_ff[g] <= `VIRS_IN_NONE;
         end else if (manual_route_enable_ff) begin                                // R11
            conv_ff[g] <= man_route;                                               // R07 R10
         end else begin
            conv_ff[g] <= sel_route[g];
         end
      end
   end

   // format always follows the selection code, even under manual override
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         core_format_o <= VIRS_FMT_COMPOSITE;
      end else begin
         core_format_o <= sel_fmt;                                                 // R02 R10
      end
   end

   assign conv0_input_o = conv_ff[0];
   assign conv1_input_o = conv_ff[1];
   assign conv2_input_o = conv_ff[2];

   // ----------------------------------------------------------------------
   // power-down
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         core_power_down_o <= 1'b0;
      end else if (!power_down_priority_ff) begin
         core_power_down_o <= !power_down_n_pin_i;                                 // R12 R08
      end else begin
         core_power_down_o <= power_down_bit_ff;
      end
   end

   // ----------------------------------------------------------------------
   // output drivers
   // ----------------------------------------------------------------------
   logic drive_ff;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         drive_ff                 <= 1'b0;
         pixel_o                  <= '0;
         horiz_sync_out_o         <= 1'b0;
         vert_sync_out_o          <= 1'b0;
         subcarrier_lock_stream_o <= 1'b0;
      end else begin
         drive_ff                 <= !output_enable_n_i && !tristate_ff;          // R09
         pixel_o                  <= pixel_i;
         horiz_sync_out_o         <= horiz_sync_i;
         vert_sync_out_o          <= vert_sync_i;
         subcarrier_lock_stream_o <= subcarrier_lock_i;
      end
   end

   assign pixel_oe_o           = {PIX_W{drive_ff}};                                // R09
   assign horiz_sync_oe_o      = drive_ff;
   assign vert_sync_oe_o       = drive_ff;
   assign subcarrier_lock_oe_o = drive_ff;

endmodule : virs_route_select

// >>> test/virs_route_select_assertions.sv
module virs_route_select_checker
   import virs_pkg::*;
#(
   parameter int PIX_W = 20
) (
   input wire logic                mclk_i,               // clock
   input wire logic                rst_b_i,              // sync reset
   input wire logic                reg_wr_i,             // write strobe
   input wire logic [7:0]          reg_addr_i,           // address
   input wire logic [7:0]          reg_wdata_i,          // write data
   input wire logic                power_down_n_pin_i,   // power-down pin
   input wire logic                output_enable_n_i,    // output-enable pin
   input wire logic [PIX_W-1:0]    pixel_oe_o,           // pixel enables
   input wire logic                horiz_sync_oe_o,      // hsync enable
   input wire logic                vert_sync_oe_o,       // vsync enable
   input wire logic                subcarrier_lock_oe_o, // lock enable
   input wire virs_pkg::virs_input_t conv0_input_o,      // converter 0
   input wire virs_pkg::virs_input_t conv1_input_o,      // converter 1
   input wire virs_pkg::virs_input_t conv2_input_o,      // converter 2
   input wire virs_pkg::virs_fmt_t core_format_o,        // decode format
   input wire logic                core_power_down_o     // core power-down
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // shadow of the control registers
   // ----------------------------------------
   logic [3:0] sel_ff, r0_ff, cvbs_exp, man_exp;
   logic       man_ff, tri_ff, prio_ff, pd_ff;
   virs_fmt_t  fmt_exp;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         {sel_ff, r0_ff, man_ff, tri_ff, prio_ff, pd_ff} <= '0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            8'h00: sel_ff <= reg_wdata_i[3:0];
            8'h03: tri_ff <= reg_wdata_i[6];
            8'h0F: {pd_ff, prio_ff} <= {reg_wdata_i[5], reg_wdata_i[2]};
            8'hC3: r0_ff <= reg_wdata_i[3:0];
            8'hC4: man_ff <= reg_wdata_i[7];
            default: ;
         endcase
      end
   end

   always_comb begin
      fmt_exp  = (sel_ff inside {[4'h6:4'h8]}) ? VIRS_FMT_YC :
                 (sel_ff inside {4'h9, 4'hA}) ? VIRS_FMT_COMPONENT : VIRS_FMT_COMPOSITE;
      cvbs_exp = (sel_ff > 4'h5) ? sel_ff - 4'h4 : sel_ff + 4'h1;
      man_exp  = (r0_ff inside {[4'h1:4'h6]}) ? r0_ff : (r0_ff inside {[4'h9:4'hE]}) ? r0_ff - 4'h2 : 4'h0;
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   chk_drive_flag: assert property ($past(rst_b_i) |->
      pixel_oe_o[0] == (!$past(output_enable_n_i) && !$past(tri_ff))) else $error("drive flag wrong");
   chk_enables_agree: assert property (pixel_oe_o == {PIX_W{pixel_oe_o[0]}} && horiz_sync_oe_o == pixel_oe_o[0]
      && vert_sync_oe_o == pixel_oe_o[0] && subcarrier_lock_oe_o == pixel_oe_o[0]) else $error("enables differ");
   chk_pin_power_down: assert property ($past(rst_b_i) && !$past(prio_ff) |->
      core_power_down_o == !$past(power_down_n_pin_i)) else $error("pin power-down wrong");
   chk_bit_power_down: assert property ($past(rst_b_i) && $past(prio_ff) |->
      core_power_down_o == $past(pd_ff)) else $error("bit power-down wrong");
   chk_format_follows_sel: assert property ($past(rst_b_i) |-> core_format_o == $past(fmt_exp))
      else $error("format wrong");
   chk_composite_route: assert property ($past(rst_b_i) && !$past(man_ff) && $past(fmt_exp) == VIRS_FMT_COMPOSITE
      |-> conv0_input_o == $past(cvbs_exp)) else $error("composite route wrong");
   chk_no_input_twelve: assert property ($past(rst_b_i) && !$past(man_ff) |->
      conv0_input_o != 4'hC && conv1_input_o != 4'hC && conv2_input_o != 4'hC) else $error("input 12 selected");
   chk_manual_conv0: assert property ($past(rst_b_i) && $past(man_ff) |-> conv0_input_o == $past(man_exp))
      else $error("manual route wrong");
   chk_reset_default: assert property ($rose(rst_b_i) |=>
      conv0_input_o == 4'h1 && core_format_o == VIRS_FMT_COMPOSITE) else $error("reset route wrong");

   cov_manual_twelve: cover property (man_ff && conv0_input_o == 4'hC);
   cov_component: cover property (core_format_o == VIRS_FMT_COMPONENT);
   cov_bit_power_down: cover property (prio_ff && core_power_down_o);
endmodule : virs_route_select_checker

// >>> test/virs_route_select_tb.sv
module virs_route_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import virs_pkg::*;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic        power_down_n_pin_i = 1'b1, output_enable_n_i = 1'b1;
   logic        horiz_sync_i = 1'b0, vert_sync_i = 1'b1, subcarrier_lock_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [19:0] pixel_i = 20'hA5C3F, pixel_o, pixel_oe_o;
   logic        horiz_sync_out_o, horiz_sync_oe_o, vert_sync_out_o, vert_sync_oe_o;
   logic        subcarrier_lock_stream_o, subcarrier_lock_oe_o, core_power_down_o;
   virs_input_t conv0_input_o, conv1_input_o, conv2_input_o;
   virs_fmt_t   core_format_o;
   logic [3:0]  s;
   int          error_cnt = 0, compares = 0;

   virs_route_select #(
      .PIX_W(20)
   ) virs_route_select_i (
      .mclk_i                   (mclk_i),
      .rst_b_i                  (rst_b_i),
      .reg_wr_i                 (reg_wr_i),
      .reg_rd_i                 (reg_rd_i),
      .reg_addr_i               (reg_addr_i),
      .reg_wdata_i              (reg_wdata_i),
      .reg_rdata_o              (reg_rdata_o),
      .power_down_n_pin_i       (power_down_n_pin_i),
      .output_enable_n_i        (output_enable_n_i),
      .pixel_i                  (pixel_i),
      .horiz_sync_i             (horiz_sync_i),
      .vert_sync_i              (vert_sync_i),
      .subcarrier_lock_i        (subcarrier_lock_i),
      .pixel_o                  (pixel_o),
      .pixel_oe_o               (pixel_oe_o),
      .horiz_sync_out_o         (horiz_sync_out_o),
      .horiz_sync_oe_o          (horiz_sync_oe_o),
      .vert_sync_out_o          (vert_sync_out_o),
      .vert_sync_oe_o           (vert_sync_oe_o),
      .subcarrier_lock_stream_o (subcarrier_lock_stream_o),
      .subcarrier_lock_oe_o     (subcarrier_lock_oe_o),
      .conv0_input_o            (conv0_input_o),
      .conv1_input_o            (conv1_input_o),
      .conv2_input_o            (conv2_input_o),
      .core_format_o            (core_format_o),
      .core_power_down_o        (core_power_down_o)
   );

   always #4 mclk_i = ~mclk_i;

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic settle();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
      settle();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1;
      cmp("read data", 20'(e), 20'(reg_rdata_o));
   endtask : rd

   task automatic pins(input logic pd, input logic oe);
      @(posedge mclk_i);
      power_down_n_pin_i <= pd;
      output_enable_n_i  <= oe;
      pixel_i            <= ~pixel_i;
      {horiz_sync_i, vert_sync_i, subcarrier_lock_i} <= ~{horiz_sync_i, vert_sync_i, subcarrier_lock_i};
      settle();
   endtask : pins

   task automatic outs(input logic pd, input logic drv);
      cmp("power down", 20'(pd), 20'(core_power_down_o));
      cmp("pixel oe", {20{drv}}, pixel_oe_o);
      cmp("sync oe", 20'({3{drv}}), 20'({horiz_sync_oe_o, vert_sync_oe_o, subcarrier_lock_oe_o}));
      cmp("pixel", pixel_i, pixel_o);
      cmp("sync", 20'({horiz_sync_i, vert_sync_i, subcarrier_lock_i}),
          20'({horiz_sync_out_o, vert_sync_out_o, subcarrier_lock_stream_o}));
   endtask : outs

   function automatic logic [3:0] man(input logic [3:0] c, input logic [15:0] m);
      man = !m[c] ? 4'h0 : (c > 4'h8) ? c - 4'h2 : c;
   endfunction : man

   task automatic complete_run();
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      settle();
      rd(8'h00, 8'h00);
      cmp("reset conv0", 20'h1, 20'(conv0_input_o));
      cmp("reset format", 20'(VIRS_FMT_COMPOSITE), 20'(core_format_o));
      for (int i = 0; i < 16; i++) begin
         s = 4'(i);
         wr(8'h00, {4'h0, s});
         cmp("sel conv0", 20'(64'hBA98_7213_2165_4321 >> (4 * i) & 64'hF), 20'(conv0_input_o));
         cmp("sel format", 20'(32'h0029_5000 >> (2 * i) & 32'h3), 20'(core_format_o));
         if (s inside {[4'h6:4'hA]}) cmp("sel conv1", 20'(64'h0346_5400_0000 >> (4 * i) & 64'hF), 20'(conv1_input_o));
         if (s inside {4'h9, 4'hA}) cmp("sel conv2", (s == 4'h9) ? 20'h5 : 20'h6, 20'(conv2_input_o));
      end
      wr(8'h00, 8'h06);
      for (int i = 0; i < 16; i++) begin
         s = 4'(i);
         wr(8'hC3, {s, s});
         wr(8'hC4, {4'h8, s});
         cmp("man conv0", 20'(man(s, 16'h7E7E)), 20'(conv0_input_o));
         cmp("man conv1", 20'(man(s, 16'h7878)), 20'(conv1_input_o));
         cmp("man conv2", 20'(man(s, 16'h6464)), 20'(conv2_input_o));
         cmp("man format", 20'(VIRS_FMT_YC), 20'(core_format_o));
      end
      rd(8'hC4, 8'h8F);
      wr(8'hC3, 8'hEE);
      wr(8'hC4, 8'h0E);
      cmp("off conv01", 20'h14, 20'({conv0_input_o, conv1_input_o}));
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      pins(1'b0, 1'b1);
      outs(1'b1, 1'b0);
      wr(8'h0F, 8'h20);
      pins(1'b1, 1'b0);
      outs(1'b0, 1'b1);
      wr(8'h0F, 8'h24);
      outs(1'b1, 1'b1);
      wr(8'h0F, 8'h04);
      pins(1'b0, 1'b0);
      outs(1'b0, 1'b1);
      wr(8'h03, 8'h40);
      outs(1'b0, 1'b0);
      rd(8'h03, 8'h40);
      // mid-run reset must bring the selection, tristate and power-down fields back to their defaults
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      settle();
      rd(8'h00, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h0F, 8'h00);
      cmp("rerst conv0", 20'h1, 20'(conv0_input_o));
      cmp("rerst format", 20'(VIRS_FMT_COMPOSITE), 20'(core_format_o));
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      complete_run();
   end
endmodule : virs_route_select_tb

bind virs_route_select virs_route_select_checker #(
   .PIX_W(PIX_W)
) virs_route_select_checker_i (
   .mclk_i               (mclk_i),
   .rst_b_i              (rst_b_i),
   .reg_wr_i             (reg_wr_i),
   .reg_addr_i           (reg_addr_i),
   .reg_wdata_i          (reg_wdata_i),
   .power_down_n_pin_i   (power_down_n_pin_i),
   .output_enable_n_i    (output_enable_n_i),
   .pixel_oe_o           (pixel_oe_o),
   .horiz_sync_oe_o      (horiz_sync_oe_o),
   .vert_sync_oe_o       (vert_sync_oe_o),
   .subcarrier_lock_oe_o (subcarrier_lock_oe_o),
   .conv0_input_o        (conv0_input_o),
   .conv1_input_o        (conv1_input_o),
   .conv2_input_o        (conv2_input_o),
   .core_format_o        (core_format_o),
   .core_power_down_o    (core_power_down_o)
);
